// >>> rtl/eax_core.sv
// Address generation datapath plus the extension, clock-pair,
// translation and debug-tag special registers.
// Assumes register-file values arrive with the request and that
// requests are synchronous to clk_i.
`timescale 1ns/1ps
module eax_core #(
  parameter int TICK_DIV = eax_pkg::RTC_TICK_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Machine state
  input wire logic [eax_pkg::XLEN-1:0] machine_state_reg_i,
  // Address request
  input wire logic ea_req_i,
  input wire eax_pkg::eax_amode_t ea_mode_i,
  input wire logic [eax_pkg::XLEN-1:0] insn_i,
  input wire logic [eax_pkg::XLEN-1:0] pc_i,
  input wire logic [eax_pkg::XLEN-1:0] base_val_i,
  input wire logic [eax_pkg::XLEN-1:0] index_val_i,
  input wire logic [3:0] ea_len_i,
  input wire logic is_store_i,
  // Address result
  output logic ea_valid_o,
  output logic [eax_pkg::XLEN-1:0] effective_address_o,
  output logic [eax_pkg::XLEN-1:0] ea_last_o,
  output logic ea_wrap_o,
  output logic mem_write_o,
  // Computation using the extension register
  input wire eax_pkg::eax_op_t alu_op_i,
  input wire logic [eax_pkg::XLEN-1:0] alu_a_i,
  input wire logic [eax_pkg::XLEN-1:0] alu_b_i,
  input wire logic [4:0] alu_sh_i,
  output logic alu_valid_o,
  output logic [eax_pkg::XLEN-1:0] alu_result_o,
  output logic [eax_pkg::XLEN-1:0] mq_o,
  // Special register move port
  input wire logic spr_req_i,
  input wire logic spr_write_i,
  input wire logic [eax_pkg::REGNUM_W-1:0] special_register_i,
  input wire logic [eax_pkg::XLEN-1:0] spr_wdata_i,
  output logic spr_ack_o,
  output logic spr_fault_o,
  output logic spr_unmapped_o,
  output logic [eax_pkg::XLEN-1:0] spr_rdata_o,
  // Debug tag
  output logic [eax_pkg::TAG_W-1:0] processor_tag_o
);
  import eax_pkg::*;

  eax_ag_if ag ();
  eax_addr_gen u_gen (.ag(ag));

  // Instruction fields decode beside the adder, never after it
  logic [FIELD_W-1:0] base_reg_field;
  logic [FIELD_W-1:0] index_reg_field;
  logic [XLEN-1:0] base_or_zero;
  logic [XLEN-1:0] imm_sext;
  logic [XLEN-1:0] br_sext;
  assign base_reg_field = insn_i[BASE_LSB +: FIELD_W];
  assign index_reg_field = insn_i[INDEX_LSB +: FIELD_W];
  assign imm_sext = {{16{insn_i[15]}}, insn_i[15:0]};
  assign br_sext = {{6{insn_i[25]}}, insn_i[25:2], 2'b00};
  assign base_or_zero = (base_reg_field == 5'h00) ? '0 : base_val_i;

  // Operand selection per addressing form
  always_comb begin
    ag.base = base_or_zero;
    ag.addend = imm_sext;
    ag.len = ea_len_i;
    case (ea_mode_i)
      EAX_AM_IMM: begin
        ag.addend = imm_sext;
      end
      EAX_AM_IDX: begin
        ag.addend = index_val_i;
      end
      EAX_AM_SEQ: begin
        ag.base = {pc_i[XLEN-1:2], 2'b00};
        ag.addend = INSN_BYTES;
        ag.len = 4'h4;
      end
      EAX_AM_BRANCH: begin
        ag.base = {pc_i[XLEN-1:2], 2'b00};
        ag.addend = br_sext;
        ag.len = 4'h4;
      end
      default: begin
        ag.addend = imm_sext;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ea_valid_o <= 1'b0;
      effective_address_o <= '0;
      ea_last_o <= '0;
      ea_wrap_o <= 1'b0;
      mem_write_o <= 1'b0;
    end else begin
      ea_valid_o <= ea_req_i;
      if (ea_req_i) begin
        effective_address_o <= ag.ea;
        ea_last_o <= ag.last;
        ea_wrap_o <= ag.wrap;
      end
      mem_write_o <= ea_req_i && is_store_i && alu_op_i == EAX_OP_NONE
        && (ea_mode_i == EAX_AM_IMM || ea_mode_i == EAX_AM_IDX);
    end
  end

  // Privilege and special register decode
  logic user_mode;
  logic hit_ext, hit_rtc_rd, hit_rtc_wr, hit_bat, hit_impl15;
  logic supv_only, mapped, spr_fault, spr_go;
  logic [2:0] bat_idx;
  assign user_mode = machine_state_reg_i[PRIV_USER_BIT];
  assign hit_ext = special_register_i == NUM_EXT;
  assign hit_rtc_rd = !spr_write_i && (special_register_i == NUM_CLK_HI_RD
    || special_register_i == NUM_CLK_LO_RD);
  assign hit_rtc_wr = spr_write_i && (special_register_i == NUM_CLK_HI_WR
    || special_register_i == NUM_CLK_LO_WR);
  assign hit_bat = special_register_i[9:3] == NUM_XLT_BASE[9:3];
  assign hit_impl15 = special_register_i == NUM_IMPL15;
  assign bat_idx = special_register_i[2:0]; // Even upper, odd lower
  assign supv_only = hit_rtc_wr || hit_bat || hit_impl15;
  assign mapped = hit_ext || hit_rtc_rd || hit_rtc_wr || hit_bat
    || hit_impl15;
  assign spr_fault = spr_req_i && mapped && user_mode && supv_only;
  assign spr_go = spr_req_i && mapped && !spr_fault;

  // Clock-pair tick divider; one-cycle enable pulse
  logic [15:0] div_reg;
  logic tick;
  assign tick = div_reg == 16'(TICK_DIV - 1);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= tick ? '0 : div_reg + 16'h0001;
    end
  end

  logic [XLEN-1:0] rtclock_upper_reg, rtclock_lower_reg;
  logic [XLEN-1:0] rtclock_upper_next, rtclock_lower_next;
  logic wr_clk_hi, wr_clk_lo;
  assign wr_clk_hi = spr_go && hit_rtc_wr
    && special_register_i == NUM_CLK_HI_WR;
  assign wr_clk_lo = spr_go && hit_rtc_wr
    && special_register_i == NUM_CLK_LO_WR;
  // Software writes win over the tick so a load is never lost
  always_comb begin
    rtclock_lower_next = rtclock_lower_reg;
    rtclock_upper_next = rtclock_upper_reg;
    if (tick) begin
      rtclock_lower_next = rtclock_lower_reg + 32'h0000_0001;
      if (&rtclock_lower_reg) begin
        rtclock_upper_next = rtclock_upper_reg + 32'h0000_0001;
      end
    end
    if (wr_clk_lo) begin
      rtclock_lower_next = spr_wdata_i;
    end
    if (wr_clk_hi) begin
      rtclock_upper_next = spr_wdata_i;
    end
  end

  logic [XLEN-1:0] block_xlate_reg [NUM_BAT];
  logic [TAG_W-1:0] processor_tag_reg;
  logic [XLEN-1:0] mq_reg, mq_next, alu_next;

  // Extension register datapath
  logic [2*XLEN-1:0] prod, dividend, quot, rem, shl, rot2;
  assign prod = {{XLEN{1'b0}}, alu_a_i} * {{XLEN{1'b0}}, alu_b_i};
  assign dividend = {alu_a_i, mq_reg};
  assign quot = dividend / {32'h0000_0000, alu_b_i};
  assign rem = dividend % {32'h0000_0000, alu_b_i};
  assign shl = {alu_a_i, mq_reg} << alu_sh_i;
  assign rot2 = {alu_a_i, alu_a_i} << alu_sh_i;

  always_comb begin
    mq_next = mq_reg;
    alu_next = '0;
    case (alu_op_i)
      EAX_OP_MUL: begin
        alu_next = prod[2*XLEN-1:XLEN];
        mq_next = prod[XLEN-1:0];
      end
      EAX_OP_DIV: begin
        if (alu_b_i != '0) begin
          alu_next = quot[XLEN-1:0];
          mq_next = rem[XLEN-1:0];
        end else begin
          alu_next = '1; // Divide by zero leaves extension alone
        end
      end
      EAX_OP_ROTL: begin
        alu_next = rot2[2*XLEN-1:XLEN];
        mq_next = rot2[2*XLEN-1:XLEN];
      end
      EAX_OP_SHL: begin
        alu_next = shl[2*XLEN-1:XLEN];
        mq_next = shl[XLEN-1:0];
      end
      default: begin
        if (spr_go && hit_ext && spr_write_i) begin
          mq_next = spr_wdata_i;
        end
      end
    endcase
  end

  // Register updates
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mq_reg <= EXT_RST;
      rtclock_upper_reg <= RTC_RST;
      rtclock_lower_reg <= RTC_RST;
      alu_valid_o <= 1'b0;
      alu_result_o <= '0;
    end else begin
      mq_reg <= mq_next;
      rtclock_upper_reg <= rtclock_upper_next;
      rtclock_lower_reg <= rtclock_lower_next;
      alu_valid_o <= alu_op_i != EAX_OP_NONE;
      alu_result_o <= alu_next;
    end
  end

  // Translation pairs and tag: supervisor writes only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_BAT; i++) begin
        block_xlate_reg[i] <= BAT_RST;
      end
      processor_tag_reg <= TAG_RST;
    end else if (spr_go && spr_write_i) begin
      if (hit_bat) begin
        block_xlate_reg[bat_idx] <= spr_wdata_i;
      end
      if (hit_impl15) begin
        processor_tag_reg <= spr_wdata_i[TAG_W-1:0];
      end
    end
  end

  // Read mux; narrow fields read back zero-extended
  logic [XLEN-1:0] rd_mux;
  assign rd_mux = hit_ext ? mq_reg
    : (hit_rtc_rd && special_register_i == NUM_CLK_HI_RD) ? rtclock_upper_reg
    : hit_rtc_rd ? rtclock_lower_reg
    : hit_bat ? block_xlate_reg[bat_idx]
    : hit_impl15 ? {{(XLEN-TAG_W){1'b0}}, processor_tag_reg}
    : '0;

  // Move port answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      spr_ack_o <= 1'b0;
      spr_fault_o <= 1'b0;
      spr_unmapped_o <= 1'b0;
      spr_rdata_o <= '0;
    end else begin
      spr_ack_o <= spr_req_i;
      spr_fault_o <= spr_fault;
      spr_unmapped_o <= spr_req_i && !mapped;
      spr_rdata_o <= (spr_go && !spr_write_i) ? rd_mux : '0;
    end
  end

  assign mq_o = mq_reg;
  assign processor_tag_o = processor_tag_reg;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_user_rtc_wr;
    spr_req_i && spr_write_i && user_mode && hit_rtc_wr
      |=> spr_fault_o && spr_ack_o;
  endproperty
  a_user_rtc_wr: assert property (p_user_rtc_wr)
    else $error("user clock write not refused");

  property p_user_rtc_rd;
    spr_req_i && !spr_write_i && user_mode && hit_rtc_rd
      |=> !spr_fault_o && spr_ack_o;
  endproperty
  a_user_rtc_rd: assert property (p_user_rtc_rd)
    else $error("user clock read refused");

  property p_rd_num_on_write;
    spr_req_i && spr_write_i && (special_register_i == NUM_CLK_HI_RD
      || special_register_i == NUM_CLK_LO_RD) |=> spr_unmapped_o;
  endproperty
  a_rd_num_on_write: assert property (p_rd_num_on_write)
    else $error("read number accepted for a write");

  property p_mul_ext;
    alu_op_i == EAX_OP_MUL |=> mq_reg == $past(prod[XLEN-1:0])
      && alu_result_o == $past(prod[2*XLEN-1:XLEN]);
  endproperty
  a_mul_ext: assert property (p_mul_ext)
    else $error("product split wrong");

  property p_shl_ext;
    alu_op_i == EAX_OP_SHL |=> {alu_result_o, mq_reg}
      == ($past({alu_a_i, mq_reg}) << $past(alu_sh_i));
  endproperty
  a_shl_ext: assert property (p_shl_ext)
    else $error("long shift wrong");

  property p_ea_one_cycle;
    ea_req_i |=> ea_valid_o ##1 (ea_valid_o == $past(ea_req_i));
  endproperty
  a_ea_one_cycle: assert property (p_ea_one_cycle)
    else $error("address not ready in one cycle");

  property p_imm_zero_base;
    ea_req_i && ea_mode_i == EAX_AM_IMM && base_reg_field == 5'h00
      |=> effective_address_o == $past(imm_sext);
  endproperty
  a_imm_zero_base: assert property (p_imm_zero_base)
    else $error("zero base field not literal zero");

  property p_idx_sum;
    ea_req_i && ea_mode_i == EAX_AM_IDX && base_reg_field != 5'h00
      |=> effective_address_o == $past(base_val_i) + $past(index_val_i);
  endproperty
  a_idx_sum: assert property (p_idx_sum)
    else $error("indexed address wrong");

  property p_wrap;
    ea_valid_o && ea_wrap_o |-> ea_last_o < effective_address_o;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap flag without wrap");

  property p_no_alu_store;
    alu_op_i != EAX_OP_NONE |=> !mem_write_o;
  endproperty
  a_no_alu_store: assert property (p_no_alu_store)
    else $error("computation wrote memory");

  property p_tag;
    spr_req_i && spr_write_i && !user_mode && hit_impl15
      |=> processor_tag_o == $past(spr_wdata_i[TAG_W-1:0]);
  endproperty
  a_tag: assert property (p_tag)
    else $error("tag not stored");
endmodule : eax_core

// >>> rtl/eax_pkg.sv
// Package for the address generator and extra register block.
// Assumes one 200 MHz core clock and a synchronous active-high reset.
package eax_pkg;
  localparam int XLEN = 32;
  localparam int REGNUM_W = 10;
  localparam int PRIV_USER_BIT = 14; // Set means user privilege
  localparam int TAG_W = 4;
  localparam int NUM_BAT = 8;
  localparam logic [XLEN-1:0] INSN_BYTES = 32'h0000_0004;
  // Special register numbers
  localparam logic [REGNUM_W-1:0] NUM_EXT = 10'h010;
  localparam logic [REGNUM_W-1:0] NUM_CLK_HI_RD = 10'h020;
  localparam logic [REGNUM_W-1:0] NUM_CLK_LO_RD = 10'h021;
  localparam logic [REGNUM_W-1:0] NUM_CLK_HI_WR = 10'h030;
  localparam logic [REGNUM_W-1:0] NUM_CLK_LO_WR = 10'h031;
  localparam logic [REGNUM_W-1:0] NUM_XLT_BASE = 10'h040;
  localparam logic [REGNUM_W-1:0] NUM_IMPL15 = 10'h04F;
  // Values after reset
  localparam logic [XLEN-1:0] EXT_RST = 32'h0000_0000;
  localparam logic [XLEN-1:0] RTC_RST = 32'h0000_0000;
  localparam logic [XLEN-1:0] BAT_RST = 32'h0000_0000;
  localparam logic [TAG_W-1:0] TAG_RST = 4'h0;
  // Core cycles per clock-pair tick
  localparam int RTC_TICK_DIV = 16;
  // Instruction field positions
  localparam int BASE_LSB = 16;
  localparam int INDEX_LSB = 11;
  localparam int FIELD_W = 5;
  typedef enum logic [2:0] {
    EAX_OP_NONE, EAX_OP_MUL, EAX_OP_DIV, EAX_OP_ROTL, EAX_OP_SHL
  } eax_op_t;
  typedef enum logic [1:0] {
    EAX_AM_IMM, EAX_AM_IDX, EAX_AM_SEQ, EAX_AM_BRANCH
  } eax_amode_t;
endpackage : eax_pkg

// >>> rtl/eax_ag_if.sv
// Carrier between the top and the address adder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface eax_ag_if;
  import eax_pkg::*;
  logic [XLEN-1:0] base;
  logic [XLEN-1:0] addend;
  logic [3:0] len;
  logic [XLEN-1:0] ea;
  logic [XLEN-1:0] last;
  logic wrap;
  modport top (output base, output addend, output len,
    input ea, input last, input wrap);
  modport gen (input base, input addend, input len,
    output ea, output last, output wrap);
endinterface : eax_ag_if

// >>> rtl/eax_addr_gen.sv
// Combinational effective-address adder with operand wrap detection.
// Assumes the caller has already chosen base and addend.
`timescale 1ns/1ps
module eax_addr_gen (
  // Operands in, address out
  eax_ag_if.gen ag
);
  import eax_pkg::*;
  logic [XLEN:0] last_sum;
  logic [XLEN-1:0] len_m1;
  assign ag.ea = ag.base + ag.addend;
  // Last byte of the operand; a carry here means it ran past the top
  assign len_m1 = XLEN'(ag.len) - 32'h0000_0001;
  assign last_sum = {1'b0, ag.ea} + {1'b0, len_m1};
  assign ag.last = last_sum[XLEN-1:0];
  // A zero-length operand touches no byte, so it can never wrap
  assign ag.wrap = last_sum[XLEN] && (ag.len != 4'h0);
endmodule : eax_addr_gen

// >>> bench/tb.sv
// Self-checking bench for the address generator and extra registers.
// Assumes eax_core with a long clock-pair tick so reads move by one at most.
`timescale 1ns/1ps
module tb;
  import eax_pkg::*;
  logic clk_i, reset_i, req, store, sreq, swr;
  logic [XLEN-1:0] machine_state_reg, insn, pc, bval, ival, a, b, wd, mq_m, rv, x;
  logic [3:0] len;
  logic [4:0] sh;
  eax_amode_t mode;
  eax_op_t op;
  logic [REGNUM_W-1:0] snum;
  logic ea_v, wrap, mw, alu_v, ack, flt, unm;
  logic [XLEN-1:0] ea, last, res, mq, rd;
  logic [TAG_W-1:0] tag;
  integer err_count, checks_done, seed, cyc, k;

  eax_core #(.TICK_DIV(500)) DUT (.clk_i(clk_i), .reset_i(reset_i),
    .machine_state_reg_i(machine_state_reg), .ea_req_i(req), .ea_mode_i(mode),
    .insn_i(insn), .pc_i(pc), .base_val_i(bval), .index_val_i(ival),
    .ea_len_i(len), .is_store_i(store), .ea_valid_o(ea_v),
    .effective_address_o(ea), .ea_last_o(last), .ea_wrap_o(wrap),
    .mem_write_o(mw), .alu_op_i(op), .alu_a_i(a), .alu_b_i(b),
    .alu_sh_i(sh), .alu_valid_o(alu_v), .alu_result_o(res), .mq_o(mq),
    .spr_req_i(sreq), .spr_write_i(swr), .special_register_i(snum),
    .spr_wdata_i(wd), .spr_ack_o(ack), .spr_fault_o(flt),
    .spr_unmapped_o(unm), .spr_rdata_o(rd), .processor_tag_o(tag));

  // Free-running 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard, far above the planned run length
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [XLEN-1:0] e, g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Inputs move 1 ns after the rising edge, never on it
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic ea_do(input eax_amode_t m, input logic [XLEN-1:0] i, p,
      bv, iv, input logic [3:0] l, input logic st);
    logic [XLEN-1:0] bs, e;
    logic [32:0] s;
    logic mwx;
    bs = (i[20:16] == 5'h00) ? 32'h0000_0000 : bv;
    e = (m == EAX_AM_IMM) ? bs + {{16{i[15]}}, i[15:0]} :
      (m == EAX_AM_IDX) ? bs + iv :
      (m == EAX_AM_SEQ) ? {p[31:2], 2'b00} + INSN_BYTES :
      {p[31:2], 2'b00} + {{6{i[25]}}, i[25:2], 2'b00};
    if (m == EAX_AM_SEQ || m == EAX_AM_BRANCH) l = 4'h4;
    s = {1'b0, e} + {29'h0, l} - 33'h1;
    // Only a plain store, with no computation beside it, writes memory
    mwx = st && m < EAX_AM_SEQ && op == EAX_OP_NONE;
    mode = m; insn = i; pc = p; bval = bv; ival = iv; len = l;
    store = st; req = 1'b1;
    step();
    req = 1'b0;
    chk("ea_valid", 32'h1, {31'h0, ea_v});
    chk("ea", e, ea);
    chk("ea_last", s[31:0], last);
    chk("ea_wrap", {31'h0, s[32] && l != 4'h0}, {31'h0, wrap});
    chk("mem_write", {31'h0, mwx}, {31'h0, mw});
    step();
    chk("ea_hold", e, ea);
  endtask : ea_do

  task automatic alu_do(input eax_op_t o, input logic [XLEN-1:0] p, q,
      input logic [4:0] s);
    logic [63:0] w;
    logic [XLEN-1:0] r, nm;
    nm = mq_m;
    case (o)
      EAX_OP_MUL: {r, nm} = {32'h0, p} * {32'h0, q};
      EAX_OP_DIV: begin
        r = 32'hFFFF_FFFF;
        if (q != 32'h0) begin
          w = {p, mq_m} / {32'h0, q};
          r = w[31:0];
          w = {p, mq_m} % {32'h0, q};
          nm = w[31:0];
        end
      end
      EAX_OP_SHL: {r, nm} = {p, mq_m} << s;
      default: begin
        r = (p << s) | (p >> (6'd32 - s));
        nm = r;
      end
    endcase
    op = o; a = p; b = q; sh = s;
    step();
    op = EAX_OP_NONE;
    mq_m = nm;
    chk("alu_valid", 32'h1, {31'h0, alu_v});
    chk("alu_result", r, res);
    chk("ext", nm, mq);
    step();
  endtask : alu_do

  // Privilege comes from one bit; the rest of the state word is noise
  task automatic spr_do(input logic w, input logic [REGNUM_W-1:0] n,
      input logic [XLEN-1:0] d, input logic u, ef, eu);
    logic [XLEN-1:0] sw;
    sw = $random(seed);
    sw[PRIV_USER_BIT] = u;
    machine_state_reg = sw;
    swr = w; snum = n; wd = d; sreq = 1'b1;
    step();
    sreq = 1'b0;
    rv = rd;
    chk("spr_ack", 32'h1, {31'h0, ack});
    chk("spr_fault", {31'h0, ef}, {31'h0, flt});
    chk("spr_unmapped", {31'h0, eu}, {31'h0, unm});
    if (w || ef || eu) chk("spr_rdata", 32'h0, rv);
    step();
  endtask : spr_do

  initial begin
    err_count = 0; checks_done = 0; seed = 95; cyc = 0; mq_m = 32'h0;
    reset_i = 1'b1; req = 1'b0; store = 1'b0; sreq = 1'b0; swr = 1'b0;
    machine_state_reg = 32'h0; insn = 32'h0; pc = 32'h0; bval = 32'h0; ival = 32'h0;
    a = 32'h0; b = 32'h0; wd = 32'h0; len = 4'h4; sh = 5'h00;
    mode = EAX_AM_IMM; op = EAX_OP_NONE; snum = 10'h000;
    repeat (20) step();
    reset_i = 1'b0;
    chk("ext_reset", 32'h0, mq);
    chk("tag_reset", 32'h0, {28'h0, tag});
    // Corner cases: wrap past the top, zero base field, dropped carry
    ea_do(EAX_AM_IMM, 32'h0000_FFFC, 32'h0, 32'h55, 32'h0, 4'h8, 1'b1);
    ea_do(EAX_AM_IDX, 32'h0000_0000, 32'h0, 32'h99, 32'h10, 4'h1, 1'b0);
    ea_do(EAX_AM_IDX, 32'h0003_0000, 32'h0, 32'hFFFF_FFFF, 32'h2, 4'h4,
      1'b1);
    ea_do(EAX_AM_IMM, 32'h0001_0000, 32'h0, 32'hFFFF_FFF0, 32'h0, 4'h0,
      1'b0);
    ea_do(EAX_AM_SEQ, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 4'h1, 1'b1);
    for (k = 0; k < 200; k++) begin
      ea_do(eax_amode_t'($random(seed)), $random(seed), $random(seed),
        $random(seed), $random(seed), 4'($random(seed)), $random(seed));
    end
    // Computation corners then random traffic
    alu_do(EAX_OP_MUL, 32'h8000_0000, 32'h4, 5'h00);
    alu_do(EAX_OP_DIV, 32'h1234, 32'h0, 5'h00);
    alu_do(EAX_OP_ROTL, 32'h8000_0001, 32'h0, 5'h00);
    alu_do(EAX_OP_SHL, 32'hF000_000F, 32'h0, 5'h1F);
    for (k = 0; k < 150; k++) begin
      x = $random(seed);
      alu_do(eax_op_t'(3'(x[1:0]) + 3'd1), {1'b0, x[31:1]} % 32'h3,
        $random(seed), 5'($random(seed)));
      alu_do(eax_op_t'(3'(x[3:2]) + 3'd1), $random(seed), $random(seed),
        5'($random(seed)));
    end
    // A store issued beside a running computation must not write memory
    op = EAX_OP_MUL;
    ea_do(EAX_AM_IMM, 32'h0, 32'h0, 32'h0, 32'h0, 4'h4, 1'b1);
    op = EAX_OP_NONE;
    // Extension register through the move port, user level
    x = $random(seed);
    spr_do(1'b1, NUM_EXT, x, 1'b1, 1'b0, 1'b0);
    spr_do(1'b0, NUM_EXT, 32'h0, 1'b1, 1'b0, 1'b0);
    chk("ext_read", x, rv);
    mq_m = x;
    alu_do(EAX_OP_DIV, 32'h0, 32'h7, 5'h00);
    // Clock pair: supervisor write, user read, user write refused
    spr_do(1'b1, NUM_CLK_LO_WR, 32'h0000_1230, 1'b0, 1'b0, 1'b0);
    spr_do(1'b0, NUM_CLK_LO_RD, 32'h0, 1'b1, 1'b0, 1'b0);
    chk("clk_lo_near", 32'h1, {31'h0, (rv - 32'h1230) <= 32'h1});
    x = $random(seed);
    spr_do(1'b1, NUM_CLK_HI_WR, x, 1'b0, 1'b0, 1'b0);
    spr_do(1'b1, NUM_CLK_HI_WR, ~x, 1'b1, 1'b1, 1'b0);
    spr_do(1'b0, NUM_CLK_HI_RD, 32'h0, 1'b1, 1'b0, 1'b0);
    chk("clk_hi", x, rv);
    // Swapped numbers and an unknown number are not decoded
    spr_do(1'b0, NUM_CLK_HI_WR, 32'h0, 1'b0, 1'b0, 1'b1);
    spr_do(1'b1, NUM_CLK_LO_RD, 32'h7, 1'b0, 1'b0, 1'b1);
    spr_do(1'b0, 10'h3FF, 32'h0, 1'b0, 1'b0, 1'b1);
    // Eight translation registers, supervisor only
    for (k = 0; k < NUM_BAT; k++) begin
      spr_do(1'b1, NUM_XLT_BASE + REGNUM_W'(k), 32'hA5A5_0000 + k,
        1'b0, 1'b0, 1'b0);
    end
    for (k = 0; k < NUM_BAT; k++) begin
      spr_do(1'b0, NUM_XLT_BASE + REGNUM_W'(k), 32'h0,
        1'b0, 1'b0, 1'b0);
      chk("bat", 32'hA5A5_0000 + k, rv);
      spr_do(1'b0, NUM_XLT_BASE + REGNUM_W'(k), 32'h0,
        1'b1, 1'b1, 1'b0);
    end
    // Processor tag, user write refused
    spr_do(1'b1, NUM_IMPL15, 32'hFFFF_FFF9, 1'b0, 1'b0, 1'b0);
    spr_do(1'b1, NUM_IMPL15, 32'h6, 1'b1, 1'b1, 1'b0);
    chk("tag", 32'h9, {28'h0, tag});
    spr_do(1'b0, NUM_IMPL15, 32'h0, 1'b0, 1'b0, 1'b0);
    chk("tag_read", 32'h9, rv);
    step();
    complete_run();
  end
endmodule : tb
